// ==== core/sic_host.sv ====
// host sequencer that drives the serial unit's registers for simplified bus use
// assumes the device register port runs on I_LCLK and answers each access with I_REG_ACK
//
// How it works
// - each transaction is finished by a stop command leaving the bus released
// - stop: trigger stop, clear output enable, data low, clock high, wait, data high
// - a fixed wait separates clock rise and data rise in the stop
// - last-receive command clears output enable before final byte
// - divider value zero is refused and never written
// - device duty is fifty percent; user picks a large enough divider
// - clock-change preparation writes the all-stop value 000F to the unit stop register
// - overrun: read data, read status, write its two flag bits (mask 0003) to flag clear
// - ack error: clear flag, stop, make stop then start, restart channel
// - repeated-start resend is left to the user after recovery
`timescale 1ns/1ps
`include "sic_params.svh"

module sic_host
   import sic_pkg::*;
(
   input  wire logic        I_MCLK,       // system clock
   input  wire logic        I_RESETN,     // async reset, low
   input  wire logic        I_LCLK,       // device register port clock
   input  wire logic        I_CMD_VALID,  // command request
   input  wire logic [2:0]  I_CMD,        // command code
   input  wire logic        I_CHAN,       // channel 0 or 1
   input  wire logic [6:0]  I_DIVIDER,    // bit rate divider
   input  wire logic [3:0]  I_PRESCALE,   // prescale code
   input  wire logic        I_CLK_SEL,    // prescaler field select
   output logic             O_CMD_READY,  // command accepted when high
   output logic             O_DONE,       // command finished pulse
   output logic             O_ERROR,      // last command refused
   output logic [15:0]      O_RESULT,     // last status or data read
   output logic [7:0]       O_REG_ADDR,   // register address
   output logic [15:0]      O_REG_WDATA,  // register write data
   output logic             O_REG_WR,     // write strobe, held to ack
   output logic             O_REG_RD,     // read strobe, held to ack
   input  wire logic [15:0] I_REG_RDATA,  // read data, valid with ack
   input  wire logic        I_REG_ACK     // access complete
);

   localparam logic [9:0] WAIT_CYC = 10'(`SIC_STOP_WAIT_CYC);

   // system side: command hold and handshake toggles
   logic        busy;
   logic        req_tgl;
   logic [2:0]  cmd_h;
   logic        chan_h;
   logic [6:0]  div_h;
   logic [3:0]  prs_h;
   logic        cks_h;
   logic        ack_s1, ack_s2, ack_s3;

   // link side
   logic        req_s1, req_s2, req_s3;
   logic        ack_tgl;
   sic_lstate_e lstate;
   logic [2:0]  cmd_l;
   logic        chan_l;
   logic [6:0]  div_l;
   logic [3:0]  prs_l;
   logic        cks_l;
   logic [4:0]  step;
   logic [9:0]  wait_cnt;
   logic [15:0] rd_val;
   logic [15:0] res_l;
   logic        err_l;
   sic_op_s     op;
   logic [15:0] next_wdata;
   logic [15:0] mask;

   // micro-op table: each command is a short list of register accesses
   function automatic sic_op_s seq_op(input logic [2:0] c, input logic [4:0] s);
      sic_op_s o;
      o = '{OP_END, 8'h00, 1'b0};
      case (c)
         CMD_STOP, CMD_ACK_FIX: begin
            logic [4:0] t;
            t = (c == CMD_ACK_FIX) ? s - 5'd2 : ((s > 5'd7) ? 5'd31 : s); // plain stop ends
            if (c == CMD_ACK_FIX && s == 5'd0) o = '{OP_RD, `SIC_ADDR_STATUS, 1'b0};
            else if (c == CMD_ACK_FIX && s == 5'd1) o = '{OP_WR_RDV, `SIC_ADDR_FLAG_CLEAR, 1'b0};
            else begin
               case (t)
                  5'd0: o = '{OP_WR_BIT, `SIC_ADDR_UNIT_STOP, 1'b0};
                  5'd1: o = '{OP_RD, `SIC_ADDR_UNIT_OUT_EN, 1'b0};
                  5'd2: o = '{OP_WR_CLR, `SIC_ADDR_UNIT_OUT_EN, 1'b0};
                  5'd3: o = '{OP_RD, `SIC_ADDR_OUT_LEVEL, 1'b0};
                  5'd4: o = '{OP_WR_CLR, `SIC_ADDR_OUT_LEVEL, 1'b0};   // data low
                  5'd5: o = '{OP_WR_SET, `SIC_ADDR_OUT_LEVEL, 1'b1};   // clock high
                  5'd6: o = '{OP_WAIT, 8'h00, 1'b0};
                  5'd7: o = '{OP_WR_SET, `SIC_ADDR_OUT_LEVEL, 1'b0};   // data high
                  5'd8:  o = '{OP_WAIT, 8'h00, 1'b0};
                  5'd9:  o = '{OP_WR_CLR, `SIC_ADDR_OUT_LEVEL, 1'b0};  // start
                  5'd10: o = '{OP_WAIT, 8'h00, 1'b0};
                  5'd11: o = '{OP_WR_CLR, `SIC_ADDR_OUT_LEVEL, 1'b1};
                  5'd12: o = '{OP_RD, `SIC_ADDR_UNIT_OUT_EN, 1'b0};
                  5'd13: o = '{OP_WR_SET, `SIC_ADDR_UNIT_OUT_EN, 1'b0};
                  5'd14: o = '{OP_WR_BIT, `SIC_ADDR_UNIT_START, 1'b0};
                  default: o = '{OP_END, 8'h00, 1'b0};
               endcase
            end
         end
         CMD_OVERRUN: begin
            case (s)
               5'd0: o = '{OP_RD, `SIC_ADDR_DATA_DIV, 1'b0};
               5'd1: o = '{OP_RD, `SIC_ADDR_STATUS, 1'b0};
               5'd2: o = '{OP_WR_RDV, `SIC_ADDR_FLAG_CLEAR, 1'b0};
            endcase
         end
         CMD_SET_RATE: begin
            case (s)
               5'd0: o = '{OP_WR_BIT, `SIC_ADDR_UNIT_STOP, 1'b0};
               5'd1: o = '{OP_RD, `SIC_ADDR_CHAN_MODE, 1'b0};
               5'd2: o = '{OP_WR_CKS, `SIC_ADDR_CHAN_MODE, 1'b0};
               5'd3: o = '{OP_RD, `SIC_ADDR_PRESCALE, 1'b0};
               5'd4: o = '{OP_WR_PRS, `SIC_ADDR_PRESCALE, 1'b0};
               5'd5: o = '{OP_RD, `SIC_ADDR_DATA_DIV, 1'b0};
               5'd6: o = '{OP_WR_DIV, `SIC_ADDR_DATA_DIV, 1'b0};
               5'd7: o = '{OP_WR_BIT, `SIC_ADDR_UNIT_START, 1'b0};
            endcase
         end
         CMD_CLK_PREP: if (s == 5'd0) o = '{OP_WR_ALL, `SIC_ADDR_UNIT_STOP, 1'b0};
         CMD_LAST_RX: begin
            case (s)
               5'd0: o = '{OP_RD, `SIC_ADDR_UNIT_OUT_EN, 1'b0};
               5'd1: o = '{OP_WR_CLR, `SIC_ADDR_UNIT_OUT_EN, 1'b0};
            endcase
         end
         CMD_START: if (s == 5'd0) o = '{OP_WR_BIT, `SIC_ADDR_UNIT_START, 1'b0};
      endcase
      return o;
   endfunction

   // system side: accept a command while idle and toggle the request
   always_ff @(posedge I_MCLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         busy    <= 1'b0;
         req_tgl <= 1'b0;
         cmd_h   <= 3'h7;
         chan_h  <= 1'b0;
         div_h   <= 7'h00;
         prs_h   <= 4'h0;
         cks_h   <= 1'b0;
      end else if (I_CMD_VALID && !busy) begin
         busy    <= 1'b1;
         req_tgl <= ~req_tgl;
         cmd_h   <= I_CMD;
         chan_h  <= I_CHAN;
         div_h   <= I_DIVIDER;
         prs_h   <= I_PRESCALE;
         cks_h   <= I_CLK_SEL;
      end else if (ack_s2 != ack_s3) begin
         busy    <= 1'b0;
      end
   end

   assign O_CMD_READY = !busy;

   // acknowledge toggle crosses back; result is stable once it lands
   always_ff @(posedge I_MCLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         ack_s1   <= 1'b0;
         ack_s2   <= 1'b0;
         ack_s3   <= 1'b0;
         O_DONE   <= 1'b0;
         O_ERROR  <= 1'b0;
         O_RESULT <= 16'h0000;
      end else begin
         ack_s1 <= ack_tgl;
         ack_s2 <= ack_s1;
         ack_s3 <= ack_s2;
         O_DONE <= (ack_s2 != ack_s3);
         if (ack_s2 != ack_s3) begin
            O_ERROR  <= err_l;
            O_RESULT <= res_l;
         end
      end
   end

   // link side: request toggle synchroniser
   always_ff @(posedge I_LCLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         req_s1 <= 1'b0;
         req_s2 <= 1'b0;
         req_s3 <= 1'b0;
      end else begin
         req_s1 <= req_tgl;
         req_s2 <= req_s1;
         req_s3 <= req_s2;
      end
   end

   // write data for the current op; read-modify-write keeps other channels' bits
   assign op   = seq_op(cmd_l, step);
   assign mask = op.cko ? 16'(16'h0001 << (`SIC_CKO_SHIFT + chan_l)) : 16'(16'h0001 << chan_l);
   always_comb begin
      next_wdata = rd_val;
      unique case (op.kind)
         OP_WR_BIT: next_wdata = 16'(16'h0001 << chan_l);
         OP_WR_ALL: next_wdata = `SIC_ALL_STOP;
         OP_WR_CLR: next_wdata = rd_val & ~mask;
         OP_WR_SET: next_wdata = rd_val | mask;
         OP_WR_RDV: next_wdata = rd_val & `SIC_FLAG_MASK;
         OP_WR_CKS: next_wdata = {cks_l, rd_val[14:0]};
         OP_WR_PRS: next_wdata = cks_l ? {rd_val[15:8], prs_l, rd_val[3:0]}
                                       : {rd_val[15:4], prs_l};
         OP_WR_DIV: next_wdata = {div_l, rd_val[`SIC_DIV_LSB-1:0]};
         default:   next_wdata = rd_val;
      endcase
   end

   // link side sequencer; strobes are held until the device acknowledges
   always_ff @(posedge I_LCLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         lstate      <= LS_IDLE;
         ack_tgl     <= 1'b0;
         cmd_l       <= 3'h7;
         chan_l      <= 1'b0;
         div_l       <= 7'h00;
         prs_l       <= 4'h0;
         cks_l       <= 1'b0;
         step        <= 5'd0;
         wait_cnt    <= 10'd0;
         rd_val      <= 16'h0000;
         res_l       <= 16'h0000;
         err_l       <= 1'b0;
         O_REG_ADDR  <= 8'h00;
         O_REG_WDATA <= 16'h0000;
         O_REG_WR    <= 1'b0;
         O_REG_RD    <= 1'b0;
      end else begin
         unique case (lstate)
            LS_IDLE: if (req_s2 != req_s3) begin // held fields settled before the toggle
               cmd_l  <= cmd_h;
               chan_l <= chan_h;
               div_l  <= div_h;
               prs_l  <= prs_h;
               cks_l  <= cks_h;
               step   <= 5'd0;
               err_l  <= (cmd_h == CMD_SET_RATE) &&
                         (div_h < `SIC_DIV_MIN || prs_h > `SIC_PRS_MAX);
               lstate <= ((cmd_h == CMD_SET_RATE) &&
                          (div_h < `SIC_DIV_MIN || prs_h > `SIC_PRS_MAX)) ? LS_DONE : LS_LOAD;
            end
            LS_LOAD: begin
               if (op.kind == OP_END) begin
                  lstate <= LS_DONE;
               end else if (op.kind == OP_WAIT) begin
                  wait_cnt <= WAIT_CYC;
                  lstate   <= LS_DELAY;
               end else begin
                  O_REG_ADDR  <= op.addr;
                  O_REG_WDATA <= next_wdata;
                  O_REG_RD    <= (op.kind == OP_RD);
                  O_REG_WR    <= (op.kind != OP_RD);
                  lstate      <= LS_ACCESS;
               end
            end
            LS_ACCESS: if (I_REG_ACK) begin
               O_REG_WR <= 1'b0;
               O_REG_RD <= 1'b0;
               rd_val   <= O_REG_RD ? I_REG_RDATA : O_REG_WDATA;
               if (O_REG_RD && (O_REG_ADDR == `SIC_ADDR_STATUS ||
                                O_REG_ADDR == `SIC_ADDR_DATA_DIV)) begin
                  res_l <= I_REG_RDATA;
               end
               step   <= step + 5'd1;
               lstate <= LS_LOAD;
            end
            LS_DELAY: begin // link clock is slower, so the wait only grows
               if (wait_cnt <= 10'd1) begin
                  step   <= step + 5'd1;
                  lstate <= LS_LOAD;
               end
               wait_cnt <= wait_cnt - 10'd1;
            end
            LS_DONE: begin
               ack_tgl <= ~ack_tgl;
               lstate  <= LS_IDLE;
            end
            default: lstate <= LS_IDLE;
         endcase
      end
   end

endmodule

// ==== core/sic_params.svh ====
// offsets, field positions and timing counts for the simplified bus host
// assumes the serial unit exposes 16-bit registers at 8-bit addresses
`ifndef SIC_PARAMS_SVH
`define SIC_PARAMS_SVH

// register addresses on the device register port
`define SIC_ADDR_UNIT_STOP    8'h00
`define SIC_ADDR_UNIT_START   8'h01
`define SIC_ADDR_UNIT_ENABLE  8'h02
`define SIC_ADDR_UNIT_OUT_EN  8'h03
`define SIC_ADDR_OUT_LEVEL    8'h04
`define SIC_ADDR_DATA_DIV     8'h05
`define SIC_ADDR_STATUS       8'h06
`define SIC_ADDR_FLAG_CLEAR   8'h07
`define SIC_ADDR_CHAN_MODE    8'h08
`define SIC_ADDR_PRESCALE     8'h09

// field layout
`define SIC_CKO_SHIFT         8
`define SIC_CKS_BIT           15
`define SIC_DIV_LSB           9
`define SIC_FLAG_MASK         16'h0003
`define SIC_ALL_STOP          16'h000F
`define SIC_PRS_MAX           4'hB
`define SIC_DIV_MIN           7'h01

// timing
`define SIC_MCLK_MHZ          100
`define SIC_STOP_WAIT_NS      5000
`define SIC_STOP_WAIT_CYC     ((`SIC_STOP_WAIT_NS * `SIC_MCLK_MHZ + 999) / 1000)

`endif

// ==== core/sic_pkg.sv ====
// types shared by the simplified bus host
// assumes sic_params.svh supplies the numeric constants
package sic_pkg;

   typedef enum logic [2:0] {
      CMD_STOP     = 3'h0,
      CMD_OVERRUN  = 3'h1,
      CMD_ACK_FIX  = 3'h2,
      CMD_SET_RATE = 3'h3,
      CMD_CLK_PREP = 3'h4,
      CMD_LAST_RX  = 3'h5,
      CMD_START    = 3'h6,
      CMD_NONE     = 3'h7
   } sic_cmd_e;

   typedef enum logic [3:0] {
      OP_END    = 4'h0,
      OP_RD     = 4'h1,
      OP_WR_BIT = 4'h2,
      OP_WR_ALL = 4'h3,
      OP_WR_CLR = 4'h4,
      OP_WR_SET = 4'h5,
      OP_WR_RDV = 4'h6,
      OP_WR_CKS = 4'h7,
      OP_WR_PRS = 4'h8,
      OP_WR_DIV = 4'h9,
      OP_WAIT   = 4'hA
   } sic_kind_e;

   typedef struct packed {
      sic_kind_e  kind;
      logic [7:0] addr;
      logic       cko;
   } sic_op_s;

   typedef enum logic [2:0] {
      LS_IDLE   = 3'h0,
      LS_LOAD   = 3'h1,
      LS_ACCESS = 3'h2,
      LS_DELAY  = 3'h3,
      LS_DONE   = 3'h4
   } sic_lstate_e;

endpackage

// ==== test/sic_dev_model.sv ====
// register model of the serial unit: triggers, flags and pin levels
// assumes strobes stand until answered and one access at a time
`timescale 1ns/1ps
module sic_dev_model (
   input  wire logic        i_clk,   // port clock
   input  wire logic        i_rst_n, // reset, low
   input  wire logic [7:0]  i_addr,  // address
   input  wire logic [15:0] i_wdata, // write data
   input  wire logic        i_wr,    // write
   input  wire logic        i_rd,    // read
   input  wire logic [1:0]  i_dly,   // latency
   input  wire logic [1:0]  i_err,   // flags to raise
   output logic [15:0]      o_rdata, // read data
   output logic             o_ack,   // answer
   output logic [1:0]       o_sda    // data pins
);
   logic [15:0] r [0:15];
   logic [1:0]  cnt;
   int          gap;
   int          lgap;
   // output enable clear: pin holds the written bit; with output enable set, shift logic idles high
   assign o_sda = r[3][1:0] | r[4][1:0];
   // answer after i_dly cycles; rate fields kept as written for the divider
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         r <= '{default: 16'h0000};
         r[3] <= 16'h0003;
         r[4] <= 16'h0303;
         {cnt, o_ack, o_rdata} <= '0;
      end else begin
         r[6] <= r[6] | {13'h0, i_err[0], i_err};
         o_ack <= 1'b0;
         o_rdata <= ~o_rdata; // a released bus shows no stale value
         if ((i_wr || i_rd) && !o_ack) begin
            cnt <= (cnt == i_dly) ? 2'h0 : cnt + 2'h1;
            if (cnt == i_dly) begin
               o_ack <= 1'b1;
               if (i_rd) o_rdata <= r[i_addr[3:0]];
               if (i_rd && i_addr == 8'h05) r[6][2] <= 1'b0;
               if (i_wr) case (i_addr)
                  8'h00: r[2] <= r[2] & ~i_wdata;
                  8'h01: r[2] <= r[2] | i_wdata;
                  8'h02, 8'h06: ; // enable and status are read only
                  8'h07: r[6] <= r[6] & ~(i_wdata & 16'h0003);
                  default: r[i_addr[3:0]] <= i_wdata;
               endcase
            end
         end
      end
   end
   // cycles between level writes, to time the wait inside a stop
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         gap <= 0;
         lgap <= 0;
      end else if (i_wr && o_ack && i_addr == 8'h04) begin
         lgap <= gap;
         gap <= 0;
      end else gap <= gap + 1;
   end
endmodule

// ==== test/sic_host_assertions.sv ====
// assertions on the host's command handshake and its register-port accesses
// assumes a bind onto sic_host; it sees only that module's ports
`timescale 1ns/1ps
`include "sic_params.svh"
module sic_host_chk (
   input wire logic        I_MCLK,      // clock
   input wire logic        I_RESETN,    // reset
   input wire logic        I_LCLK,      // port clock
   input wire logic        I_CMD_VALID, // request
   input wire logic        O_CMD_READY, // idle
   input wire logic        O_DONE,      // finish
   input wire logic [7:0]  O_REG_ADDR,  // address
   input wire logic [15:0] O_REG_WDATA, // data
   input wire logic        O_REG_WR,    // write
   input wire logic        O_REG_RD,    // read
   input wire logic        I_REG_ACK    // answer
);
   logic       acc;
   logic [7:0] wa;
   // access in flight, and the address of a write (FF when none is made)
   assign acc = O_REG_WR || O_REG_RD;
   assign wa = O_REG_WR ? O_REG_ADDR : 8'hFF;
   property p_take; @(posedge I_MCLK) disable iff (!I_RESETN)
      I_CMD_VALID && O_CMD_READY |=> !O_CMD_READY; endproperty
   a_take: assert property (p_take) else $error("ready after take");
   property p_busy; @(posedge I_MCLK) disable iff (!I_RESETN)
      $fell(O_CMD_READY) |-> !O_DONE [*3]; endproperty
   a_busy: assert property (p_busy) else $error("done too early");
   property p_hold; @(posedge I_LCLK) disable iff (!I_RESETN)
      acc && !I_REG_ACK |=> acc && $stable({O_REG_WR, O_REG_ADDR, O_REG_WDATA}); endproperty
   a_hold: assert property (p_hold) else $error("access not held");
   property p_gap; @(posedge I_LCLK) disable iff (!I_RESETN)
      acc && I_REG_ACK |=> !acc; endproperty
   a_gap: assert property (p_gap) else $error("no idle after answer");
   property p_div; @(posedge I_LCLK) disable iff (!I_RESETN)
      wa == `SIC_ADDR_DATA_DIV |-> O_REG_WDATA[15:9] != 7'h00; endproperty
   a_div: assert property (p_div) else $error("zero divider written");
   property p_clr; @(posedge I_LCLK) disable iff (!I_RESETN)
      wa == `SIC_ADDR_FLAG_CLEAR |-> (O_REG_WDATA & ~`SIC_FLAG_MASK) == 16'h0000; endproperty
   a_clr: assert property (p_clr) else $error("clear not masked");
   property p_stop; @(posedge I_LCLK) disable iff (!I_RESETN)
      wa == `SIC_ADDR_UNIT_STOP |-> O_REG_WDATA inside {16'h0001, 16'h0002, 16'h000F};
   endproperty
   a_stop: assert property (p_stop) else $error("bad stop value");
   property p_prs; @(posedge I_LCLK) disable iff (!I_RESETN)
      wa == `SIC_ADDR_PRESCALE |-> O_REG_WDATA[3:0] <= 4'hB && O_REG_WDATA[7:4] <= 4'hB;
   endproperty
   a_prs: assert property (p_prs) else $error("bad prescale code");
endmodule
bind sic_host sic_host_chk u_chk (.I_MCLK(I_MCLK), .I_RESETN(I_RESETN), .I_LCLK(I_LCLK),
   .I_CMD_VALID(I_CMD_VALID), .O_CMD_READY(O_CMD_READY), .O_DONE(O_DONE),
   .O_REG_ADDR(O_REG_ADDR), .O_REG_WDATA(O_REG_WDATA), .O_REG_WR(O_REG_WR),
   .O_REG_RD(O_REG_RD), .I_REG_ACK(I_REG_ACK));

// ==== test/tb_top.sv ====
// self-checking bench for sic_host against the register model
// assumes design files and model are compiled before this file
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin failures++; \
   $display("mismatch %s exp %0h got %0h", n, e, s); end end
module tb_top;
   import sic_pkg::*;
   logic        mclk, lclk, rst_n, valid, chan, sel, rdy, done, err, wr, rd, ack;
   logic [2:0]  cmd;
   logic [6:0]  div;
   logic [3:0]  pre;
   logic [1:0]  dly, inj, sda;
   logic [7:0]  addr;
   logic [15:0] res, wdat, rdat, dd0, ps0;
   int          failures = 0;
   int          n_tests = 0;
   sic_host dut (.I_MCLK(mclk), .I_RESETN(rst_n), .I_LCLK(lclk), .I_CMD_VALID(valid),
      .I_CMD(cmd), .I_CHAN(chan), .I_DIVIDER(div), .I_PRESCALE(pre), .I_CLK_SEL(sel),
      .O_CMD_READY(rdy), .O_DONE(done), .O_ERROR(err), .O_RESULT(res), .O_REG_ADDR(addr),
      .O_REG_WDATA(wdat), .O_REG_WR(wr), .O_REG_RD(rd), .I_REG_RDATA(rdat), .I_REG_ACK(ack));
   sic_dev_model dev (.i_clk(lclk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdat),
      .i_wr(wr), .i_rd(rd), .i_dly(dly), .i_err(inj), .o_rdata(rdat), .o_ack(ack),
      .o_sda(sda));
   // 10 ns system clock; 12 ns port clock offset so the phases drift apart
   initial begin
      mclk = 1'b0;
      lclk = 1'b0;
      fork
         forever #5 mclk = ~mclk;
         #3.3 forever #6 lclk = ~lclk;
      join
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // step to just after a system clock edge, where inputs change
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // offer one command with a random answer latency; bounded wait for done
   task automatic run(input logic [2:0] c, input logic ch);
      int k;
      cmd = c;
      chan = ch;
      dly = 2'($urandom % 4);
      valid = 1'b1;
      cyc(1);
      valid = 1'b0;
      for (k = 0; k < 5000 && done !== 1'b1; k++) cyc(1);
      if (k == 5000) begin
         failures++;
         give_verdict();
      end
   endtask
   // prescale register after a field update: select picks the upper nibble
   function automatic logic [15:0] exp_ps(logic [15:0] o, logic [3:0] p, logic s);
      return s ? {o[15:8], p, o[3:0]} : {o[15:4], p};
   endfunction
   initial begin
      int i;
      int ch;
      {valid, chan, sel, cmd, div, pre, dly, inj} = '0;
      rst_n = 1'b0;
      void'($urandom(39));
      cyc(5);
      `CHK("idle outs", 21'h100000, {rdy, done, err, wr, rd, res})
      rst_n = 1'b1;
      for (ch = 0; ch < 2; ch++) begin
         run(CMD_START, ch[0]);
         `CHK("started", 1'b1, dev.r[2][ch])
         run(CMD_STOP, ch[0]);
         `CHK("en", 1'b0, dev.r[2][ch])
         `CHK("oe", 1'b0, dev.r[3][ch])
         `CHK("levels", 2'b11, {dev.r[4][8 + ch], dev.r[4][ch]})
         `CHK("sda", 1'b1, sda[ch])
         `CHK("wait", 1'b1, dev.lgap >= 500)
      end
      $display("end stop");
      for (i = 0; i < 10; i++) begin
         div = (i == 0) ? 7'h01 : (i == 1) ? 7'h7F : 7'(1 + $urandom % 127);
         pre = (i == 1) ? 4'hB : 4'($urandom % 12);
         sel = 1'($urandom);
         if (i == 8) div = 7'h00;
         if (i == 9) pre = 4'(12 + $urandom % 4);
         dd0 = dev.r[5];
         ps0 = dev.r[9];
         run(CMD_SET_RATE, 1'($urandom));
         `CHK("refused", i >= 8, err)
         `CHK("divider", i < 8 ? {div, dd0[8:0]} : dd0, dev.r[5])
         `CHK("prescale", i < 8 ? exp_ps(ps0, pre, sel) : ps0, dev.r[9])
         if (i < 8) `CHK("select", sel, dev.r[8][15])
         `CHK("mode low", 15'h0000, dev.r[8][14:0])
      end
      $display("end rate");
      for (i = 1; i < 4; i++) begin
         inj = i[1:0];
         cyc(3);
         inj = 2'b00;
         run(CMD_OVERRUN, i[0]);
         `CHK("ovr status", 16'(i), res)
         `CHK("flags", 16'h0000, dev.r[6])
      end
      $display("end overrun");
      ch = $urandom % 2;
      inj = 2'b10;
      cyc(3);
      inj = 2'b00;
      run(CMD_ACK_FIX, ch[0]);
      `CHK("ack status", 16'h0002, res)
      `CHK("flags", 16'h0000, dev.r[6])
      `CHK("restart", 3'b110, {dev.r[2][ch], dev.r[3][ch], dev.r[4][8 + ch]})
      run(CMD_LAST_RX, ch[0]);
      `CHK("last rx", 1'b0, dev.r[3][ch])
      $display("end ack fix");
      run(CMD_START, 1'b0);
      run(CMD_START, 1'b1);
      `CHK("enable", 16'h0003, dev.r[2])
      run(CMD_CLK_PREP, 1'b0);
      `CHK("all stop", 16'h0000, dev.r[2])
      run(CMD_NONE, 1'b0);
      `CHK("none", 1'b0, err)
      $display("end start");
      give_verdict();
   end
endmodule
